// *** logic/monitor_regs_pkg.sv ***
// Package with register map, field positions, timing counts and carrier types of the monitor register slice.
`default_nettype none
package monitor_regs_pkg;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [7:0] IDX_ALERT_MASK_TWO = 8'h75;
	localparam logic [7:0] IDX_EXT_LOW_ONE = 8'h76;
	localparam logic [7:0] IDX_EXT_LOW_TWO = 8'h77;
	localparam logic [7:0] IDX_CONFIG_THREE = 8'h78;
	localparam logic [7:0] IDX_THERM_STATUS = 8'h79;
	localparam logic [7:0] IDX_CONTROL = 8'h60;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h61;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h62;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h63;
	localparam logic [7:0] IDX_UPPER_BASE = 8'h68;

	// ************************************************************
	// Reset values and field positions
	// ************************************************************
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] MASK_WRITABLE = 8'hFD;
	localparam int MASK_TWELVE = 0;
	localparam int MASK_FAN_BASE = 2;
	localparam int MASK_FAN_FOUR = 5;
	localparam int MASK_DIODE_BASE = 6;
	localparam int CFG_ALERT_PIN = 0;
	localparam int CFG_THERM_EN = 1;
	localparam int CFG_FULL_SPEED_ON_THERMAL = 2;
	localparam int CFG_FAST = 3;
	localparam int CFG_CONT_BASE = 4;
	localparam int CTRL_LOCK = 0;
	localparam int CTRL_PIN_SEL = 1;
	localparam int IRQ_THERM = 0;
	localparam int IRQ_ALERT = 1;
	localparam int IRQ_UNFREEZE = 2;
	localparam int IRQ_WIDTH = 3;
	localparam int CHANNELS = 8;
	localparam int GROUP_SIZE = 4;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ = 100;
	localparam int STEP_US = 22760;
	localparam int EXCEED_US = 45520;
	localparam int FAST_MS = 250;
	localparam int SLOW_MS = 1000;
	localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
	localparam int FAST_CYCLES = FAST_MS * 1000 * CLK_MHZ;
	localparam int SLOW_CYCLES = SLOW_MS * 1000 * CLK_MHZ;
	localparam logic [7:0] EXCEED_STEPS = 8'(EXCEED_US / STEP_US);
	localparam logic [7:0] TMR_MAX = 8'hFF;

	// ************************************************************
	// Types
	// ************************************************************
	typedef logic [9:0] reading_t;
	typedef struct packed {
		logic twelve_volt;
		logic overtemp;
		logic [3:0] fan;
		logic [1:0] diode;
	} fault_s;
	typedef enum logic {
		HOLD_LIVE = 1'b0,
		HOLD_FROZEN = 1'b1
	} hold_e;

endpackage : monitor_regs_pkg
`default_nettype wire

// *** logic/monitor_mask_config_therm_status_regs.sv ***
// Alert mask, extended-resolution, third configuration and thermal status registers behind a Wishbone slave.
`timescale 1ns/1ps
`default_nettype none
module monitor_mask_config_therm_status_regs #(
	parameter int STEP_CYCLES = monitor_regs_pkg::STEP_CYCLES,
	parameter int FAST_CYCLES = monitor_regs_pkg::FAST_CYCLES,
	parameter int SLOW_CYCLES = monitor_regs_pkg::SLOW_CYCLES
) (
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Measurement results and fault conditions
	input wire logic sample_valid_i,
	input wire logic [7:0][9:0] readings_i,
	input wire monitor_regs_pkg::fault_s faults_i,
	input wire logic thermal_timer_event_i,
	// Pins
	input wire logic tach_input_four_n_i,
	input wire logic five_volt_therm_n_i,
	input wire logic fan_pwm_two_i,
	output logic fan_drive_two_o,
	output logic alert_n_o,
	output logic fans_full_speed_o,
	// Tach control
	output logic fast_tach_o,
	output logic [3:0] continuous_tach_o,
	output logic tach_measure_o,
	// Interrupt
	output logic irq_o
);

	// ************************************************************
	// Bus decode
	// ************************************************************
	logic acc_go;
	logic wr_go;
	logic rd_go;
	logic [7:0] idx;
	logic [7:0] wdat;
	logic [7:0] rdata;
	assign acc_go = ce_i && cyc_i && stb_i && !ack_o;
	assign idx = adr_i[9:2];
	assign wr_go = acc_go && we_i && sel_i[0];
	assign rd_go = acc_go && !we_i;
	assign wdat = dat_i[7:0];

	logic [7:0] alert_mask_two_reg;
	logic [7:0] monitor_config_three_reg;
	logic [1:0] control_reg;
	logic [2:0] irq_status_reg;
	logic [2:0] irq_enable_reg;
	logic [7:0] steps_reg;
	logic [31:0] sub_cnt_reg;
	logic assert_flag_reg;
	logic therm_prev_reg;
	logic alert_prev_reg;
	logic [31:0] tach_cnt_reg;
	logic [7:0][7:0] upper_reg;
	logic [7:0][1:0] low_reg;
	monitor_regs_pkg::hold_e hold_reg [2];
	logic [1:0] unfreeze;

	// ************************************************************
	// Register writes
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			alert_mask_two_reg <= monitor_regs_pkg::RST_BYTE;
		else if (wr_go && idx == monitor_regs_pkg::IDX_ALERT_MASK_TWO)
			alert_mask_two_reg <= wdat & monitor_regs_pkg::MASK_WRITABLE;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			monitor_config_three_reg <= monitor_regs_pkg::RST_BYTE;
		else if (wr_go && idx == monitor_regs_pkg::IDX_CONFIG_THREE && !control_reg[monitor_regs_pkg::CTRL_LOCK])
			monitor_config_three_reg <= wdat;
	end

	// The lock can only be set; only a reset releases it.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			control_reg <= 2'h0;
		else if (wr_go && idx == monitor_regs_pkg::IDX_CONTROL)
		begin
			control_reg[monitor_regs_pkg::CTRL_LOCK] <= control_reg[monitor_regs_pkg::CTRL_LOCK] |
				wdat[monitor_regs_pkg::CTRL_LOCK];
			control_reg[monitor_regs_pkg::CTRL_PIN_SEL] <= wdat[monitor_regs_pkg::CTRL_PIN_SEL];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_enable_reg <= 3'h0;
		else if (wr_go && idx == monitor_regs_pkg::IDX_IRQ_ENABLE)
			irq_enable_reg <= wdat[2:0];
	end

	// ************************************************************
	// Extended-resolution capture and freeze
	// ************************************************************
	logic [7:0] upper_hit;
	assign upper_hit = (rd_go && idx[7:3] == monitor_regs_pkg::IDX_UPPER_BASE[7:3]) ? (8'h01 << idx[2:0]) : 8'h00;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_group
			logic [3:0] seen_reg;
			logic [3:0] seen_next;
			logic ext_read;
			assign ext_read = rd_go && idx == monitor_regs_pkg::IDX_EXT_LOW_ONE + 8'(g);
			assign seen_next = seen_reg | upper_hit[g*4 +: 4];
			assign unfreeze[g] = ce_i && hold_reg[g] == monitor_regs_pkg::HOLD_FROZEN && !ext_read && &seen_next;
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					hold_reg[g] <= monitor_regs_pkg::HOLD_LIVE;
					seen_reg <= 4'h0;
				end
				else if (ce_i)
				begin
					unique case (hold_reg[g])
						monitor_regs_pkg::HOLD_LIVE:
						begin
							if (ext_read)
							begin
								hold_reg[g] <= monitor_regs_pkg::HOLD_FROZEN;
								seen_reg <= 4'h0;
							end
						end
						monitor_regs_pkg::HOLD_FROZEN:
						begin
							if (ext_read)
								seen_reg <= 4'h0;
							else if (&seen_next)
							begin
								hold_reg[g] <= monitor_regs_pkg::HOLD_LIVE;
								seen_reg <= 4'h0;
							end
							else
								seen_reg <= seen_next;
						end
					endcase
				end
			end
		end
	endgenerate

	// One process owns the whole packed result store so no bit has two drivers.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			upper_reg <= '0;
			low_reg <= '0;
		end
		else if (ce_i && sample_valid_i)
		begin
			for (int ch = 0; ch < monitor_regs_pkg::CHANNELS; ch++)
			begin
				if (hold_reg[ch / monitor_regs_pkg::GROUP_SIZE] == monitor_regs_pkg::HOLD_LIVE)
				begin
					upper_reg[ch] <= readings_i[ch][9:2];
					low_reg[ch] <= readings_i[ch][1:0];
				end
			end
		end
	end

	// ************************************************************
	// Thermal input and assertion timer
	// ************************************************************
	logic therm_active;
	logic step_tick;
	logic status_read;
	logic [7:0] therm_status_view;
	assign therm_active = monitor_config_three_reg[monitor_regs_pkg::CFG_THERM_EN] &&
		!(control_reg[monitor_regs_pkg::CTRL_PIN_SEL] ? five_volt_therm_n_i : tach_input_four_n_i);
	assign step_tick = therm_active && sub_cnt_reg == 32'(STEP_CYCLES - 1);
	assign status_read = rd_go && idx == monitor_regs_pkg::IDX_THERM_STATUS;
	assign therm_status_view = (steps_reg >= monitor_regs_pkg::EXCEED_STEPS) ? steps_reg :
		{7'h00, assert_flag_reg};

	// A partial step is dropped when the input releases, so short pulses never accumulate.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sub_cnt_reg <= 32'h0;
		else if (ce_i)
			sub_cnt_reg <= (!therm_active || step_tick) ? 32'h0 : sub_cnt_reg + 32'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			steps_reg <= monitor_regs_pkg::RST_BYTE;
			assert_flag_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			assert_flag_reg <= therm_active || (assert_flag_reg && !status_read);
			if (status_read)
				steps_reg <= step_tick ? 8'h01 : 8'h00;
			else if (step_tick && steps_reg != monitor_regs_pkg::TMR_MAX)
				steps_reg <= steps_reg + 8'h01;
		end
	end

	// ************************************************************
	// Alert and fan outputs
	// ************************************************************
	logic tach_four_is_therm;
	logic [7:0] unmasked;
	logic alert_now;
	logic full_speed_on_thermal_on;
	assign tach_four_is_therm = monitor_config_three_reg[monitor_regs_pkg::CFG_THERM_EN] &&
		!control_reg[monitor_regs_pkg::CTRL_PIN_SEL];
	assign unmasked[monitor_regs_pkg::MASK_TWELVE] = faults_i.twelve_volt &&
		!alert_mask_two_reg[monitor_regs_pkg::MASK_TWELVE];
	assign unmasked[1] = faults_i.overtemp;
	assign unmasked[4:2] = faults_i.fan[2:0] & ~alert_mask_two_reg[4:2];
	assign unmasked[monitor_regs_pkg::MASK_FAN_FOUR] = (tach_four_is_therm ? thermal_timer_event_i : faults_i.fan[3]) &&
		!alert_mask_two_reg[monitor_regs_pkg::MASK_FAN_FOUR];
	assign unmasked[7:6] = faults_i.diode & ~alert_mask_two_reg[7:6];
	assign alert_now = |unmasked;
	assign full_speed_on_thermal_on = therm_active && monitor_config_three_reg[monitor_regs_pkg::CFG_FULL_SPEED_ON_THERMAL];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			alert_n_o <= 1'b1;
			fan_drive_two_o <= 1'b0;
			fans_full_speed_o <= 1'b0;
		end
		else if (ce_i)
		begin
			alert_n_o <= !alert_now;
			fans_full_speed_o <= full_speed_on_thermal_on;
			if (monitor_config_three_reg[monitor_regs_pkg::CFG_ALERT_PIN])
				fan_drive_two_o <= !alert_now;
			else
				fan_drive_two_o <= full_speed_on_thermal_on || fan_pwm_two_i;
		end
	end

	// ************************************************************
	// Tach measurement pacing
	// ************************************************************
	logic [31:0] tach_period;
	assign tach_period = monitor_config_three_reg[monitor_regs_pkg::CFG_FAST] ? 32'(FAST_CYCLES) : 32'(SLOW_CYCLES);
	assign fast_tach_o = monitor_config_three_reg[monitor_regs_pkg::CFG_FAST];
	assign continuous_tach_o = monitor_config_three_reg[monitor_regs_pkg::CFG_CONT_BASE +: 4];

	// Compare with >= so a switch to the shorter period never overruns the counter.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tach_cnt_reg <= 32'h0;
			tach_measure_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (tach_cnt_reg >= tach_period - 32'h1)
			begin
				tach_cnt_reg <= 32'h0;
				tach_measure_o <= 1'b1;
			end
			else
			begin
				tach_cnt_reg <= tach_cnt_reg + 32'h1;
				tach_measure_o <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Interrupt status
	// ************************************************************
	logic [2:0] irq_events;
	logic [2:0] irq_clear;
	assign irq_events[monitor_regs_pkg::IRQ_THERM] = therm_active && !therm_prev_reg;
	assign irq_events[monitor_regs_pkg::IRQ_ALERT] = alert_now && !alert_prev_reg;
	assign irq_events[monitor_regs_pkg::IRQ_UNFREEZE] = |unfreeze;
	assign irq_clear = (wr_go && idx == monitor_regs_pkg::IDX_IRQ_CLEAR) ? wdat[2:0] : 3'h0;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_status_reg <= 3'h0;
			therm_prev_reg <= 1'b0;
			alert_prev_reg <= 1'b0;
			irq_o <= 1'b0;
		end
		else if (ce_i)
		begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
			therm_prev_reg <= therm_active;
			alert_prev_reg <= alert_now;
			irq_o <= |(irq_status_reg & irq_enable_reg);
		end
	end

	// ************************************************************
	// Read mux and bus answer
	// ************************************************************
	always_comb
	begin
		rdata = 8'h00;
		if (idx[7:3] == monitor_regs_pkg::IDX_UPPER_BASE[7:3])
			rdata = upper_reg[idx[2:0]];
		else
		begin
			unique case (idx)
				monitor_regs_pkg::IDX_ALERT_MASK_TWO: rdata = alert_mask_two_reg;
				monitor_regs_pkg::IDX_EXT_LOW_ONE: rdata = {low_reg[3], low_reg[2], low_reg[1], low_reg[0]};
				monitor_regs_pkg::IDX_EXT_LOW_TWO: rdata = {low_reg[7], low_reg[6], low_reg[5], low_reg[4]};
				monitor_regs_pkg::IDX_CONFIG_THREE: rdata = monitor_config_three_reg;
				monitor_regs_pkg::IDX_THERM_STATUS: rdata = therm_status_view;
				monitor_regs_pkg::IDX_CONTROL: rdata = {6'h00, control_reg};
				monitor_regs_pkg::IDX_IRQ_STATUS: rdata = {5'h00, irq_status_reg};
				monitor_regs_pkg::IDX_IRQ_ENABLE: rdata = {5'h00, irq_enable_reg};
				default: rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end
		else if (ce_i)
		begin
			ack_o <= acc_go;
			if (acc_go)
				dat_o <= {24'h000000, rdata};
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_lock_holds;
		wr_go && idx == monitor_regs_pkg::IDX_CONFIG_THREE && control_reg[0] |=> $stable(monitor_config_three_reg);
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("config three changed while locked");

	property p_overtemp_mask_zero;
		##1 alert_mask_two_reg[1] == 1'b0;
	endproperty
	a_overtemp_mask_zero: assert property (p_overtemp_mask_zero) else $error("overtemp mask bit not zero");

	property p_alert_low;
		ce_i && alert_now |=> !alert_n_o;
	endproperty
	a_alert_low: assert property (p_alert_low) else $error("alert not asserted for unmasked fault");

	property p_alert_high;
		ce_i && !alert_now |=> alert_n_o;
	endproperty
	a_alert_high: assert property (p_alert_high) else $error("alert asserted with no unmasked fault");

	property p_full_speed_on_thermal;
		ce_i && full_speed_on_thermal_on && !monitor_config_three_reg[0] |=> fans_full_speed_o && fan_drive_two_o;
	endproperty
	a_full_speed_on_thermal: assert property (p_full_speed_on_thermal) else $error("fans not at full speed under full_speed_on_thermal");

	property p_alert_pin;
		ce_i && monitor_config_three_reg[0] |=> fan_drive_two_o == alert_n_o;
	endproperty
	a_alert_pin: assert property (p_alert_pin) else $error("fan drive two does not follow alert");

	property p_frozen_low;
		hold_reg[1] == monitor_regs_pkg::HOLD_FROZEN && ce_i && sample_valid_i |=> $stable(low_reg[7:4]);
	endproperty
	a_frozen_low: assert property (p_frozen_low) else $error("frozen low bits updated");

	property p_timer_zero;
		steps_reg < monitor_regs_pkg::EXCEED_STEPS |-> therm_status_view[7:1] == 7'h00;
	endproperty
	a_timer_zero: assert property (p_timer_zero) else $error("timer field nonzero before limit");

	property p_read_clears;
		status_read && !therm_active ##1 ce_i && !therm_active |-> !assert_flag_reg;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("assertion flag not cleared by read");

	property p_ack_single;
		ack_o && ce_i |=> !ack_o;
	endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack held longer than one cycle");

endmodule : monitor_mask_config_therm_status_regs
`default_nettype wire

// *** test/wb_host_model.sv ***
// Wishbone classic host model that runs single register cycles for the bench.
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
	// Clock
	input wire logic clk_i,
	// Wishbone master
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [31:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	input wire logic [31:0] dat_i,
	input wire logic ack_i
);
	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 32'h00000000;
		sel_o = 4'h0;
		dat_o = 32'h00000000;
	end

	// ************************************************************
	// One cycle; address and data are inverted when released so stale values never look valid.
	// ************************************************************
	task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= {22'h000000, idx, 2'b00};
		sel_o <= 4'hF;
		dat_o <= {24'h000000, wd};
		do
			@(posedge clk_i);
		while (ack_i !== 1'b1);
		rd = dat_i[7:0];
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		adr_o <= ~adr_o;
		dat_o <= ~dat_o;
	endtask : xfer
endmodule : wb_host_model
`default_nettype wire

// *** test/test_monitor_mask_config_therm_status_regs.sv ***
// Self-checking bench of the monitor register slice.
`timescale 1ns/1ps
`default_nettype none
module test_monitor_mask_config_therm_status_regs;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic cyc, stb, we, ack_o, sv = 1'b0, tev = 1'b0, t4_n = 1'b1, t5_n = 1'b1, pwm = 1'b0;
	logic [31:0] adr, dat, dat_o;
	logic [3:0] sel;
	logic [7:0][9:0] rdg = '0;
	logic [7:0][9:0] old;
	logic [7:0] flt = 8'h00;
	logic fan_drive_two_o, alert_n_o, fans_full_speed_o, fast_tach_o, tach_measure_o, irq_o;
	logic [3:0] continuous_tach_o;
	logic [15:0] seed = 16'hE4BD;
	logic [7:0] rv;
	int fail_count = 0;
	int checked = 0;
	int cyc_cnt = 0;

	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	wb_host_model u_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(dat), .dat_i(dat_o), .ack_i(ack_o));

	monitor_mask_config_therm_status_regs #(.STEP_CYCLES(10), .FAST_CYCLES(20), .SLOW_CYCLES(50)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .sample_valid_i(sv), .readings_i(rdg),
		.faults_i(flt), .thermal_timer_event_i(tev), .tach_input_four_n_i(t4_n), .five_volt_therm_n_i(t5_n),
		.fan_pwm_two_i(pwm), .fan_drive_two_o(fan_drive_two_o), .alert_n_o(alert_n_o),
		.fans_full_speed_o(fans_full_speed_o), .fast_tach_o(fast_tach_o), .continuous_tach_o(continuous_tach_o),
		.tach_measure_o(tach_measure_o), .irq_o(irq_o));

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task rnd(output logic [7:0] v);
		seed = lfsr(seed);
		v = seed[7:0];
	endtask : rnd

	function automatic logic [7:0] lowpack(input logic [7:0][9:0] r, input int g);
		return {r[4*g+3][1:0], r[4*g+2][1:0], r[4*g+1][1:0], r[4*g][1:0]};
	endfunction : lowpack

	// Fault vector bit that a mask bit guards.
	function automatic int fbit(input int m);
		return (m == 0) ? 7 : ((m < 6) ? m : m - 6);
	endfunction : fbit

	task chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: byte %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask : chk1

	task wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_n

	task wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] x;
		u_host.xfer(1'b1, i, d, x);
	endtask : wr

	task rc(input logic [7:0] i, input logic [7:0] e);
		logic [7:0] x;
		u_host.xfer(1'b0, i, 8'h00, x);
		chk8(x, e);
	endtask : rc

	task sample();
		int k;
		for (k = 0; k < 8; k++)
		begin
			rnd(rv);
			rdg[k] <= {rv, seed[9:8]};
		end
		sv <= 1'b1;
		@(posedge clk_i);
		sv <= 1'b0;
		wait_n(2);
	endtask : sample

	// Interval between measurement pulses, second interval taken so a rate change settles.
	task per(input int e);
		int n;
		int p;
		for (p = 0; p < 2; p++)
		begin
			n = 0;
			do
			begin
				@(posedge clk_i);
				n++;
			end
			while (tach_measure_o !== 1'b1 && n < 200);
		end
		chk8(8'(n), 8'(e));
	endtask : per

	task close_out();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			fail_count++;
			close_out();
		end
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		int m;
		int g;
		int k;
		wait_n(2);
		rst_i <= 1'b0;
		rc(8'h75, 8'h00);
		rc(8'h78, 8'h00);
		rc(8'h79, 8'h00);
		wr(8'h10, 8'hFF);
		rc(8'h10, 8'h00);
		rnd(rv);
		wr(8'h75, rv);
		rc(8'h75, rv & 8'hFD);
		for (m = 0; m < 8; m++)
		begin
			if (m != 1)
			begin
				wr(8'h75, 8'h00);
				flt <= 8'h01 << fbit(m);
				wait_n(3);
				chk1(alert_n_o, 1'b0);
				wr(8'h75, 8'h01 << m);
				wait_n(3);
				chk1(alert_n_o, 1'b1);
			end
		end
		flt <= 8'h40;
		wait_n(3);
		chk1(alert_n_o, 1'b0);
		wr(8'h78, 8'h01);
		flt <= 8'h80;
		wr(8'h75, 8'h00);
		wait_n(3);
		chk1(fan_drive_two_o, 1'b0);
		flt <= 8'h00;
		wait_n(3);
		chk1(fan_drive_two_o, 1'b1);
		wr(8'h78, 8'h06);
		tev <= 1'b1;
		wait_n(3);
		chk1(alert_n_o, 1'b0);
		wr(8'h75, 8'h20);
		wait_n(3);
		chk1(alert_n_o, 1'b1);
		tev <= 1'b0;
		wr(8'h78, 8'h00);
		wr(8'h62, 8'h07);
		wr(8'h63, 8'h01);
		t4_n <= 1'b0;
		wait_n(5);
		chk1(fans_full_speed_o, 1'b0);
		t4_n <= 1'b1;
		rc(8'h79, 8'h00);
		wr(8'h78, 8'h06);
		t4_n <= 1'b0;
		wait_n(35);
		chk1(fans_full_speed_o, 1'b1);
		chk1(irq_o, 1'b1);
		t4_n <= 1'b1;
		wait_n(2);
		rc(8'h79, 8'h03);
		rc(8'h79, 8'h00);
		t4_n <= 1'b0;
		wait_n(15);
		t4_n <= 1'b1;
		wait_n(2);
		rc(8'h79, 8'h01);
		rc(8'h61, 8'h01);
		wr(8'h62, 8'h01);
		wait_n(2);
		chk1(irq_o, 1'b0);
		wr(8'h60, 8'h02);
		t4_n <= 1'b0;
		wait_n(3);
		chk1(fans_full_speed_o, 1'b0);
		t4_n <= 1'b1;
		t5_n <= 1'b0;
		wait_n(3);
		chk1(fans_full_speed_o, 1'b1);
		t5_n <= 1'b1;
		rc(8'h79, 8'h01);
		wr(8'h60, 8'h00);
		for (g = 0; g < 2; g++)
		begin
			sample();
			rc(8'h76 + 8'(g), lowpack(rdg, g));
			old = rdg;
			sample();
			rc(8'h76 + 8'(g), lowpack(old, g));
			for (k = 0; k < 4; k++)
				rc(8'h68 + 8'(4 * g + k), old[4*g+k][9:2]);
			sample();
			rc(8'h76 + 8'(g), lowpack(rdg, g));
		end
		// Thermal start on the 5 V pin and the group releases must have left their sticky bits; both releases share one bit.
		rc(8'h61, 8'h05);
		wr(8'h78, 8'h08);
		per(20);
		wr(8'h78, 8'h00);
		per(50);
		rnd(rv);
		wr(8'h78, rv);
		rc(8'h78, rv);
		chk1(fast_tach_o, rv[3]);
		chk8({4'h0, continuous_tach_o}, {4'h0, rv[7:4]});
		wr(8'h60, 8'h01);
		wr(8'h78, ~rv);
		rc(8'h78, rv);
		// A reset in mid-run must restore the defaults and release the lock.
		rst_i <= 1'b1;
		wait_n(2);
		rst_i <= 1'b0;
		rc(8'h75, 8'h00);
		rc(8'h78, 8'h00);
		wr(8'h78, 8'h0E);
		rc(8'h78, 8'h0E);
		pwm <= 1'b1;
		wait_n(3);
		chk1(fan_drive_two_o, 1'b1);
		pwm <= 1'b0;
		ce_i <= 1'b0;
		flt <= 8'h80;
		wait_n(3);
		chk1(fan_drive_two_o, 1'b1);
		chk1(alert_n_o, 1'b1);
		ce_i <= 1'b1;
		wait_n(3);
		chk1(fan_drive_two_o, 1'b0);
		chk1(alert_n_o, 1'b0);
		close_out();
	end
endmodule : test_monitor_mask_config_therm_status_regs
`default_nettype wire
